// ### inc/sccd_pkg.sv
// Constants and carrier types for the system clock select and divider.
// Assumes one oscillator clock; every other clock is modelled as ticks.
package sccd_pkg;
   // Clock divide select codes
   localparam logic [1:0] SEL_MULT = 2'h0;
   localparam logic [1:0] SEL_RSVD = 2'h1;
   localparam logic [1:0] SEL_DIV4 = 2'h2;
   localparam logic [1:0] SEL_SLOW = 2'h3;
   // Reset value of the selection
   localparam logic [1:0] SEL_RESET = SEL_DIV4;
   // System clock edges per oscillator clock for each source
   localparam logic [2:0] TICKS_X4 = 3'h4;
   localparam logic [2:0] TICKS_X2 = 3'h2;
   localparam logic [2:0] TICKS_ONE = 3'h1;
   localparam logic [2:0] TICKS_NONE = 3'h0;
   // Prescaler terminal count (divide by 256)
   localparam logic [7:0] PRESCALE_LAST = 8'hff;
   localparam logic [7:0] PRESCALE_ZERO = 8'h00;
   // Four phases per machine cycle
   localparam logic [3:0] PHASES_PER_CYCLE = 4'h4;
   localparam logic [1:0] PHASE_ZERO = 2'h0;
   // Oscillator rate and multiplier stabilization time
   localparam int CLK_MHZ = 25;
   localparam int STAB_TIME_US = 100;
   localparam int STAB_CYC_I = STAB_TIME_US * CLK_MHZ;
   localparam logic [11:0] STAB_CYC = 12'(STAB_CYC_I);
   localparam logic [11:0] STAB_ZERO = 12'h000;

   // One software write; each field has its own write strobe
   typedef struct packed {
      logic sel_we;      // Write clock divide select
      logic [1:0] sel;   // {clock_divide_select_hi, _lo}
      logic mult_we;     // Write multiplier_enable
      logic mult_en;
      logic fac_we;      // Write multiplier_factor_select
      logic factor;
   } sccd_wr_t;

   // Visible state of the power management and reset control bits
   typedef struct packed {
      logic [1:0] sel_req;  // Selection as written
      logic [1:0] sel_act;  // Selection in force
      logic mult_en;        // multiplier_enable
      logic factor;         // multiplier_factor_select
      logic stable;         // multiplier_stable_flag
   } sccd_stat_t;
endpackage

// ### hw/sccd_clock_ctrl.sv
// System clock select, prescaler, multiplier model and state generator.
// Assumes all inputs are synchronous to the oscillator clock, which is
// the only clock; faster or slower system clocks appear as tick counts.
`timescale 1ns/1ps
module sccd_clock_ctrl (
   input wire logic clock,
   input wire logic rst,
   input wire sccd_pkg::sccd_wr_t wr,
   input wire logic ring_mode_flag,
   output sccd_pkg::sccd_stat_t stat,
   output logic [2:0] sys_ticks,
   output logic [1:0] phase,
   output logic machine_cycle,
   output logic write_refused
);
   import sccd_pkg::*;

   logic [1:0] sel_req_r;   // Selection as accepted from software
   logic [1:0] sel_r;       // Selection driving the mux
   logic mult_en_r;         // Multiplier enabled
   logic factor_r;          // 1 = x4, 0 = x2
   logic stable_r;          // Multiplier stable
   logic [11:0] stab_cnt_r; // Stabilization countdown
   logic [7:0] pre_r;       // Divide-by-256 prescaler
   logic [2:0] ticks_r;     // System clock edges this oscillator clock
   logic [1:0] phase_r;     // State generator phase
   logic mcyc_r;            // Machine cycle completed
   logic refused_r;         // Last write had a refused field
   logic [2:0] ticks_nxt;
   logic [3:0] acc_nxt;
   logic wrap;
   logic sel_ok, mult_ok, fac_ok;

   // Legal selection change; from anywhere but div4 only div4 is allowed
   function automatic logic sel_legal(input logic [1:0] from,
                                      input logic [1:0] to,
                                      input logic en, input logic stb);
      logic ok;
      ok = 1'b0;
      if (to == from) begin
         ok = 1'b1;
      end else if (to == SEL_RSVD) begin
         ok = 1'b0;
      end else if (from != SEL_DIV4) begin
         ok = (to == SEL_DIV4);
      end else if (to == SEL_MULT) begin
         ok = en && stb;
      end else begin
         ok = 1'b1;
      end
      return ok;
   endfunction

   // Write acceptance terms
   always_comb begin
      sel_ok = sel_legal(sel_req_r, wr.sel, mult_en_r, stable_r);
      // Both the written and the live selection must be div4
      mult_ok = (sel_req_r == SEL_DIV4) && (sel_r == SEL_DIV4)
                && !ring_mode_flag;
      fac_ok = !mult_en_r;
   end

   // Three-way source mux as system clock edges per oscillator clock
   always_comb begin
      case (sel_r)
         SEL_MULT: ticks_nxt = factor_r ? TICKS_X4 : TICKS_X2;
         SEL_DIV4: ticks_nxt = TICKS_ONE;
         SEL_SLOW: ticks_nxt = (pre_r == PRESCALE_LAST) ? TICKS_ONE
                               : TICKS_NONE;
         default: ticks_nxt = TICKS_ONE; // Reserved code never loads
      endcase
      acc_nxt = {2'h0, phase_r} + {1'b0, ticks_nxt};
      wrap = (acc_nxt >= PHASES_PER_CYCLE);
   end

   // Software selection register, refused writes leave it alone
   always_ff @(posedge clock) begin
      if (rst) begin
         sel_req_r <= SEL_RESET;
      end else if (wr.sel_we && sel_ok) begin
         sel_req_r <= wr.sel;
      end
   end

   // Live selection changes only as a machine cycle closes, so the
   // state generator never sees a shortened phase
   always_ff @(posedge clock) begin
      if (rst) begin
         sel_r <= SEL_RESET;
      end else if (wrap) begin
         sel_r <= sel_req_r;
      end
   end

   // Multiplier enable and factor
   always_ff @(posedge clock) begin
      if (rst) begin
         mult_en_r <= 1'b0;
         factor_r <= 1'b0;
      end else begin
         if (wr.mult_we && mult_ok) begin
            mult_en_r <= wr.mult_en;
         end
         if (wr.fac_we && fac_ok) begin
            factor_r <= wr.factor;
         end
      end
   end

   // Stabilization timeout; also runs out of reset since the
   // multiplier starts disabled and unsettled
   always_ff @(posedge clock) begin
      if (rst) begin
         stab_cnt_r <= STAB_CYC;
         stable_r <= 1'b0;
      end else if (wr.mult_we && mult_ok && mult_en_r && !wr.mult_en) begin
         stab_cnt_r <= STAB_CYC;
         stable_r <= 1'b0;
      end else if (stab_cnt_r != STAB_ZERO) begin
         stab_cnt_r <= stab_cnt_r - 12'h001;
         stable_r <= (stab_cnt_r == 12'h001);
      end
   end

   // Prescaler restarts at each switch so the first slow period is whole
   always_ff @(posedge clock) begin
      if (rst || wrap || sel_r != SEL_SLOW) begin
         pre_r <= PRESCALE_ZERO;
      end else begin
         pre_r <= pre_r + 8'h01;
      end
   end

   // State generator
   always_ff @(posedge clock) begin
      if (rst) begin
         phase_r <= PHASE_ZERO;
         ticks_r <= TICKS_NONE;
         mcyc_r <= 1'b0;
      end else begin
         phase_r <= acc_nxt[1:0];
         ticks_r <= ticks_nxt;
         mcyc_r <= wrap;
      end
   end

   // Refused write indicator, one cycle
   always_ff @(posedge clock) begin
      if (rst) begin
         refused_r <= 1'b0;
      end else begin
         refused_r <= (wr.sel_we && !sel_ok) || (wr.mult_we && !mult_ok)
                      || (wr.fac_we && !fac_ok);
      end
   end

   assign stat = '{sel_req: sel_req_r, sel_act: sel_r, mult_en: mult_en_r,
                   factor: factor_r, stable: stable_r};
   assign sys_ticks = ticks_r;
   assign phase = phase_r;
   assign machine_cycle = mcyc_r;
   assign write_refused = refused_r;

   a_reset_default: assert property (@(posedge clock)
      $past(rst) |-> sel_r == SEL_DIV4 && sel_req_r == SEL_DIV4)
      else $error("Selection not div4 after reset");
   a_div4_rate: assert property (@(posedge clock) disable iff (rst)
      !$past(rst) && $past(sel_r) == SEL_DIV4 |-> ticks_r == TICKS_ONE)
      else $error("Div4 source not one tick per clock");
   a_mult_rate: assert property (@(posedge clock) disable iff (rst)
      !$past(rst) && $past(sel_r) == SEL_MULT
      |-> ticks_r == ($past(factor_r) ? TICKS_X4 : TICKS_X2))
      else $error("Multiplier tick rate wrong");
   a_slow_period: assert property (@(posedge clock) disable iff (rst)
      sel_r == SEL_SLOW && pre_r == PRESCALE_LAST
      ##1 sel_r == SEL_SLOW |-> ##1 ticks_r == TICKS_NONE)
      else $error("Slow source ticked early");
   a_cycle_phase: assert property (@(posedge clock) disable iff (rst)
      mcyc_r |-> phase_r == PHASE_ZERO)
      else $error("Machine cycle closed off phase zero");
   a_switch_boundary: assert property (@(posedge clock) disable iff (rst)
      !$past(rst) && $changed(sel_r) |-> mcyc_r && sel_r == $past(sel_req_r))
      else $error("Source switched mid machine cycle");
   a_leave_via_div4: assert property (@(posedge clock) disable iff (rst)
      !$past(rst) && $changed(sel_req_r)
      |-> $past(sel_req_r) == SEL_DIV4 || sel_req_r == SEL_DIV4)
      else $error("Selection skipped div4");
   a_no_reserved: assert property (@(posedge clock) disable iff (rst)
      sel_req_r != SEL_RSVD)
      else $error("Reserved selection accepted");
   a_stable_clear: assert property (@(posedge clock) disable iff (rst)
      $fell(mult_en_r) |-> !stable_r ##1 !stable_r)
      else $error("Stable flag not cleared on disable");
   a_mult_needs_stable: assert property (@(posedge clock) disable iff (rst)
      !$past(rst) && $changed(sel_req_r) && sel_req_r == SEL_MULT
      |-> $past(stable_r) && $past(mult_en_r))
      else $error("Multiplier picked while unstable");
   a_factor_hold: assert property (@(posedge clock) disable iff (rst)
      !$past(rst) && $changed(factor_r) |-> !$past(mult_en_r))
      else $error("Factor changed while enabled");
   a_enable_hold: assert property (@(posedge clock) disable iff (rst)
      !$past(rst) && $changed(mult_en_r)
      |-> $past(sel_r) == SEL_DIV4 && !$past(ring_mode_flag))
      else $error("Enable changed outside div4");
   a_apply_delay: assert property (@(posedge clock) disable iff (rst)
      sel_r == SEL_DIV4 && sel_req_r == SEL_SLOW |-> ##[1:4] sel_r == SEL_SLOW)
      else $error("Selection not applied within a cycle");
endmodule

// ### dv/sccd_osc_model.sv
// Oscillator model: the crystal or external source on the far side.
// Assumes nothing; it free-runs, as a crystal does, from time zero.
`timescale 1ns/1ps
module sccd_osc_model #(parameter int HALF_NS = 20) (
   output logic clock
);
   // Free-running square wave, 25 MHz by default
   initial clock = 1'b0;
   always #(HALF_NS) clock = ~clock;
endmodule

// ### dv/test_system_clock_select_divider.sv
// Self-checking bench for the clock select and divider.
// Assumes the oscillator model as the only clock source.
`timescale 1ns/1ps
module test_system_clock_select_divider;
   import sccd_pkg::*;
   logic clock, rst, ring_mode_flag, machine_cycle, write_refused;
   sccd_wr_t wr;
   sccd_stat_t stat;
   logic [2:0] sys_ticks;
   logic [1:0] phase;
   logic [4:0] q[$]; // Expected {refused, sel_req, mult_en, factor}
   logic [1:0] m_sel; // Bench view of the accepted selection
   logic m_men, m_fac, m_stab, rcv, f;
   logic [7:0] lf;
   int fails, tests_run, cyc, age;
   sccd_osc_model osc_u (.clock(clock));
   sccd_clock_ctrl dut_u (.clock(clock), .rst(rst), .wr(wr),
      .ring_mode_flag(ring_mode_flag), .stat(stat), .sys_ticks(sys_ticks),
      .phase(phase), .machine_cycle(machine_cycle),
      .write_refused(write_refused));
   // Random source, seeded below
   function automatic logic [7:0] lfsr(input logic [7:0] v);
      return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
   endfunction
   task chk(input logic ok, input string m);
      tests_run++;
      if (ok !== 1'b1) begin
         fails++;
         $display("ERROR %0t %s", $time, m);
      end
   endtask
   task results;
      $display("checks %0d mismatches %0d", tests_run, fails);
      if (fails == 0 && tests_run > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   // One write; each field judged on the state before the edge
   task put(input logic sw, input logic [1:0] s, input logic mw, me, fw,
            fc, rg);
      logic ok_s, ok_m, ok_f, bad;
      ok_s = s != 2'h1 && (m_sel == 2'h2 || s == 2'h2) &&
             (s != 2'h0 || (m_men && m_stab));
      ok_m = m_sel == 2'h2 && !rg;
      ok_f = !m_men;
      bad = (sw && !ok_s) || (mw && !ok_m) || (fw && !ok_f);
      if (sw && ok_s) m_sel = s;
      if (mw && ok_m) begin
         if (m_men && !me) m_stab = 1'b0;
         m_men = me;
      end
      if (fw && ok_f) m_fac = fc;
      q.push_back({bad, m_sel, m_men, m_fac});
      @(posedge clock);
      wr <= '{sel_we:sw, sel:s, mult_we:mw, mult_en:me, fac_we:fw,
              factor:fc};
      ring_mode_flag <= rg;
      @(posedge clock);
      wr <= '0;
      repeat (3) @(posedge clock);
   endtask
   // Length and tick count of one machine cycle after settling
   task gap(input logic [1:0] act, input int e);
      int n, s, k;
      n = 0;
      s = 0;
      k = 0;
      repeat (8) @(negedge clock);
      while (machine_cycle !== 1'b1 && k < 3000) begin
         @(negedge clock);
         k++;
      end
      do begin
         @(negedge clock);
         n++;
         s += sys_ticks;
      end while (machine_cycle !== 1'b1 && n < 3000);
      chk(stat.sel_act === act, "selection in force");
      chk(phase === 2'h0, "phase at machine cycle end");
      chk(n == e, "machine cycle length");
      chk(s == 4, "system ticks per machine cycle");
   endtask
   // Watcher: the answer to a write shows over two cycles
   always @(negedge clock) begin
      if (wr.sel_we || wr.mult_we || wr.fac_we) age = 1;
      else if (age == 1) begin
         rcv = write_refused;
         age = 2;
      end else if (age == 2) begin
         rcv = rcv | write_refused;
         age = 0;
         if (q.size() == 0) chk(1'b0, "answer without a write");
         else chk({rcv, stat.sel_req, stat.mult_en, stat.factor}
                  === q.pop_front(), "write answer");
      end
   end
   // Hang guard
   always @(posedge clock) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         fails++;
         results;
      end
   end
   initial begin
      rst = 1'b1;
      wr = '0;
      ring_mode_flag = 1'b0;
      {m_sel, m_men, m_fac, m_stab} = {2'h2, 3'h0};
      lf = 8'h2d;
      repeat (5) @(posedge clock);
      rst <= 1'b0;
      @(negedge clock);
      chk(stat === 7'h50, "reset state");
      gap(2'h2, 4);
      put(1, 2'h1, 0, 0, 0, 0, 0);
      put(1, 2'h0, 0, 0, 0, 0, 0);
      $display("reset and refusals done");
      repeat (2600) @(posedge clock);
      m_stab = 1'b1;
      chk(stat.stable === 1'b1, "stable after timeout");
      put(0, 2'h0, 1, 1, 0, 0, 1);
      lf = lfsr(lfsr(lf));
      f = lf[0];
      put(0, 2'h0, 0, 0, 1, f, 0);
      put(0, 2'h0, 1, 1, 0, 0, 0);
      put(0, 2'h0, 0, 0, 1, ~f, 0);
      put(1, 2'h0, 0, 0, 0, 0, 0);
      gap(2'h0, f ? 1 : 2);
      put(1, 2'h3, 0, 0, 0, 0, 0);
      put(1, 2'h2, 0, 0, 0, 0, 0);
      gap(2'h2, 4);
      $display("multiplier done");
      put(1, 2'h3, 0, 0, 0, 0, 0);
      gap(2'h3, 1024);
      put(0, 2'h0, 1, 0, 0, 0, 0);
      put(1, 2'h2, 0, 0, 0, 0, 0);
      gap(2'h2, 4);
      put(0, 2'h0, 1, 0, 0, 0, 0);
      chk(stat.stable === 1'b0, "flag cleared on disable");
      put(1, 2'h0, 0, 0, 0, 0, 0);
      $display("slow clock and disable done");
      results;
   end
endmodule
